/* File: rtl/echo_regs_pkg.sv */
package echo_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LEVEL_W = 16;

  // Canceller A
  localparam logic [7:0] OFS_A_SEND_PEAK_LOW = 8'h0E;
  localparam logic [7:0] OFS_A_SEND_PEAK_HIGH = 8'h0F;
  localparam logic [7:0] OFS_A_ERROR_PEAK_LOW = 8'h10;
  localparam logic [7:0] OFS_A_ERROR_PEAK_HIGH = 8'h11;
  localparam logic [7:0] OFS_A_THRESHOLD_LOW = 8'h14;
  localparam logic [7:0] OFS_A_THRESHOLD_HIGH = 8'h15;

  // Canceller B
  localparam logic [7:0] OFS_B_SEND_PEAK_LOW = 8'h2E;
  localparam logic [7:0] OFS_B_SEND_PEAK_HIGH = 8'h2F;
  localparam logic [7:0] OFS_B_ERROR_PEAK_LOW = 8'h30;
  localparam logic [7:0] OFS_B_ERROR_PEAK_HIGH = 8'h31;
  localparam logic [7:0] OFS_B_THRESHOLD_LOW = 8'h34;
  localparam logic [7:0] OFS_B_THRESHOLD_HIGH = 8'h35;

  localparam logic [7:0] THRESHOLD_LOW_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_HIGH_RESET = 8'h48;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Peak decays by peak >> PEAK_DECAY_SHIFT, or by 1 when that is zero, on every quieter sample
  localparam int PEAK_DECAY_SHIFT = 6;
  // Threshold is a Q15 fraction of the receive-path peak
  localparam int FRAC_BITS = 15;

  localparam logic [15:0] LEVEL_MAX = 16'h7FFF;

  // Magnitude of a two's complement sample, saturated at full scale
  function automatic logic [15:0] magnitude(input logic [15:0] s);
    logic [15:0] neg;
    neg = 16'h0000 - s;
    if (!s[15]) begin
      magnitude = s;
    end else if (s == 16'h8000) begin
      magnitude = LEVEL_MAX;
    end else begin
      magnitude = neg;
    end
  endfunction

endpackage

/* File: rtl/level_peak_tracker.sv */
module level_peak_tracker
  import echo_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sample_valid_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] sample_i,
  output logic [echo_regs_pkg::LEVEL_W-1:0] peak_o
);

  logic [LEVEL_W-1:0] peak_reg;
  logic [LEVEL_W-1:0] peak_next;
  logic [LEVEL_W-1:0] mag;
  logic [LEVEL_W-1:0] decay;

  assign mag = magnitude(sample_i);
  assign decay = peak_reg >> PEAK_DECAY_SHIFT;

  // Fast attack, slow release: a loud sample is caught at once
  always_comb begin
    peak_next = peak_reg;
    if (sample_valid_i) begin
      if (mag >= peak_reg) begin
        peak_next = mag;
      end else if (decay != 16'h0000) begin
        peak_next = peak_reg - decay;
      end else begin
        peak_next = peak_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peak_reg <= 16'h0000;
    end else begin
      peak_reg <= peak_next;
    end
  end

  assign peak_o = peak_reg;

endmodule

/* File: rtl/echo_peak_and_dtd_regs.sv */
// Chosen here: the address-and-strobe port.
module echo_peak_and_dtd_regs
  import echo_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [echo_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [echo_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [echo_regs_pkg::DATA_W-1:0] reg_rdata_o,
  // Canceller A sample stream
  input wire logic sample_valid_a_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] send_sample_a_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] error_sample_a_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] receive_sample_a_i,
  // Canceller B sample stream
  input wire logic sample_valid_b_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] send_sample_b_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] error_sample_b_i,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] receive_sample_b_i,
  // Detector results
  output logic double_talk_a_o,
  output logic double_talk_b_o,
  output logic [echo_regs_pkg::LEVEL_W-1:0] talk_threshold_a_o,
  output logic [echo_regs_pkg::LEVEL_W-1:0] talk_threshold_b_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level trackers, index 0 is canceller A, index 1 is canceller B

  logic [1:0] valid;
  logic [LEVEL_W-1:0] send_in [2];
  logic [LEVEL_W-1:0] error_in [2];
  logic [LEVEL_W-1:0] receive_in [2];
  logic [LEVEL_W-1:0] send_peak_level [2];
  logic [LEVEL_W-1:0] error_peak_level [2];
  logic [LEVEL_W-1:0] receive_peak [2];

  assign valid = {sample_valid_b_i, sample_valid_a_i};
  assign send_in[0] = send_sample_a_i;
  assign send_in[1] = send_sample_b_i;
  assign error_in[0] = error_sample_a_i;
  assign error_in[1] = error_sample_b_i;
  assign receive_in[0] = receive_sample_a_i;
  assign receive_in[1] = receive_sample_b_i;

  // Peaks follow the signals only; no register write reaches them
  for (genvar c = 0; c < 2; c++) begin : g_track
    level_peak_tracker u_send_peak (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .sample_valid_i(valid[c]),
      .sample_i(send_in[c]),
      .peak_o(send_peak_level[c])
    );
    level_peak_tracker u_error_peak (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .sample_valid_i(valid[c]),
      .sample_i(error_in[c]),
      .peak_o(error_peak_level[c])
    );
    level_peak_tracker u_receive_peak (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .sample_valid_i(valid[c]),
      .sample_i(receive_in[c]),
      .peak_o(receive_peak[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  typedef enum {
    SEL_NONE,
    SEL_SEND_LOW,
    SEL_SEND_HIGH,
    SEL_ERROR_LOW,
    SEL_ERROR_HIGH,
    SEL_THR_LOW,
    SEL_THR_HIGH
  } reg_sel_t;

  reg_sel_t sel;
  logic sel_b;

  always_comb begin
    sel = SEL_NONE;
    sel_b = 1'b0;
    unique case (reg_addr_i)
      OFS_A_SEND_PEAK_LOW: sel = SEL_SEND_LOW;
      OFS_A_SEND_PEAK_HIGH: sel = SEL_SEND_HIGH;
      OFS_A_ERROR_PEAK_LOW: sel = SEL_ERROR_LOW;
      OFS_A_ERROR_PEAK_HIGH: sel = SEL_ERROR_HIGH;
      OFS_A_THRESHOLD_LOW: sel = SEL_THR_LOW;
      OFS_A_THRESHOLD_HIGH: sel = SEL_THR_HIGH;
      OFS_B_SEND_PEAK_LOW: begin
        sel = SEL_SEND_LOW;
        sel_b = 1'b1;
      end
      OFS_B_SEND_PEAK_HIGH: begin
        sel = SEL_SEND_HIGH;
        sel_b = 1'b1;
      end
      OFS_B_ERROR_PEAK_LOW: begin
        sel = SEL_ERROR_LOW;
        sel_b = 1'b1;
      end
      OFS_B_ERROR_PEAK_HIGH: begin
        sel = SEL_ERROR_HIGH;
        sel_b = 1'b1;
      end
      OFS_B_THRESHOLD_LOW: begin
        sel = SEL_THR_LOW;
        sel_b = 1'b1;
      end
      OFS_B_THRESHOLD_HIGH: begin
        sel = SEL_THR_HIGH;
        sel_b = 1'b1;
      end
      default: sel = SEL_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Talk threshold storage

  logic [LEVEL_W-1:0] talk_threshold_reg [2];

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        talk_threshold_reg[c] <= {THRESHOLD_HIGH_RESET,
                                  THRESHOLD_LOW_RESET};
      end
    end else if (reg_write_i) begin
      // Peak selections fall through here untouched
      if (sel == SEL_THR_LOW) begin
        talk_threshold_reg[sel_b][7:0] <= reg_wdata_i;
      end else if (sel == SEL_THR_HIGH) begin
        talk_threshold_reg[sel_b][15:8] <= reg_wdata_i;
      end
    end
  end

  assign talk_threshold_a_o = talk_threshold_reg[0];
  assign talk_threshold_b_o = talk_threshold_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Coherent peak reads
  // Reading a low byte freezes the matching high byte, so a low-then-high
  // pair always belongs to one 16-bit value even as the peak moves.

  logic [7:0] send_high_hold_reg [2];
  logic [7:0] error_high_hold_reg [2];
  logic [1:0] send_hold_valid_reg;
  logic [1:0] error_hold_valid_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        send_high_hold_reg[c] <= 8'h00;
        error_high_hold_reg[c] <= 8'h00;
      end
      send_hold_valid_reg <= 2'b00;
      error_hold_valid_reg <= 2'b00;
    end else if (reg_read_i) begin
      unique case (sel)
        SEL_SEND_LOW: begin
          send_high_hold_reg[sel_b] <= send_peak_level[sel_b][15:8];
          send_hold_valid_reg[sel_b] <= 1'b1;
        end
        SEL_SEND_HIGH: send_hold_valid_reg[sel_b] <= 1'b0;
        SEL_ERROR_LOW: begin
          error_high_hold_reg[sel_b] <= error_peak_level[sel_b][15:8];
          error_hold_valid_reg[sel_b] <= 1'b1;
        end
        SEL_ERROR_HIGH: error_hold_valid_reg[sel_b] <= 1'b0;
        SEL_NONE, SEL_THR_LOW, SEL_THR_HIGH: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [7:0] send_high_now;
  logic [7:0] error_high_now;

  // A high byte read without a prior low read shows the live value
  assign send_high_now = send_hold_valid_reg[sel_b] ?
                         send_high_hold_reg[sel_b] :
                         send_peak_level[sel_b][15:8];
  assign error_high_now = error_hold_valid_reg[sel_b] ?
                          error_high_hold_reg[sel_b] :
                          error_peak_level[sel_b][15:8];

  always_comb begin
    rdata_next = UNMAPPED_READ;
    unique case (sel)
      SEL_SEND_LOW: rdata_next = send_peak_level[sel_b][7:0];
      SEL_SEND_HIGH: rdata_next = send_high_now;
      SEL_ERROR_LOW: rdata_next = error_peak_level[sel_b][7:0];
      SEL_ERROR_HIGH: rdata_next = error_high_now;
      SEL_THR_LOW: rdata_next = talk_threshold_reg[sel_b][7:0];
      SEL_THR_HIGH: rdata_next = talk_threshold_reg[sel_b][15:8];
      SEL_NONE: rdata_next = UNMAPPED_READ;
    endcase
  end

  // Read data stand for exactly one cycle, then return to zero
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_read_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Double-talk decision
  // Near-end speech is declared when the send level exceeds the threshold
  // fraction of the receive peak. The product is kept at full width so a
  // large threshold cannot wrap into a small limit.

  logic [1:0] double_talk_reg;
  logic [LEVEL_W-1:0] send_mag [2];
  logic [2*LEVEL_W-1:0] product [2];
  logic [LEVEL_W:0] limit [2];

  for (genvar c = 0; c < 2; c++) begin : g_detect
    assign send_mag[c] = magnitude(send_in[c]);
    // Negative thresholds are treated as zero: any send energy counts
    assign product[c] = talk_threshold_reg[c][15] ? 32'h0000_0000 :
                        talk_threshold_reg[c] * receive_peak[c];
    assign limit[c] = product[c][FRAC_BITS +: LEVEL_W + 1];
  end

  // Uses the threshold held at this edge, so a write counts from the
  // next sample onward
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      double_talk_reg <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (valid[c]) begin
          double_talk_reg[c] <= {1'b0, send_mag[c]} > limit[c];
        end
      end
    end
  end

  assign double_talk_a_o = double_talk_reg[0];
  assign double_talk_b_o = double_talk_reg[1];

endmodule

/* File: testbench/echo_peak_and_dtd_regs_properties.sv */
module echo_regs_checker
  import echo_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [echo_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [echo_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [echo_regs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic sample_valid_a_i,
  input wire logic double_talk_a_o,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] talk_threshold_a_o,
  input wire logic [echo_regs_pkg::LEVEL_W-1:0] talk_threshold_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////
  property p_rdata_idle;
    !$past(reg_read_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");
  property p_thr_b_hi;
    reg_read_i && reg_addr_i == 8'h35
      |=> reg_rdata_o == $past(talk_threshold_b_o[15:8]);
  endproperty
  a_thr_b_hi: assert property (p_thr_b_hi)
    else $error("threshold B high readback wrong");
  property p_thr_b_lo;
    reg_read_i && reg_addr_i == 8'h34
      |=> reg_rdata_o == $past(talk_threshold_b_o[7:0]);
  endproperty
  a_thr_b_lo: assert property (p_thr_b_lo)
    else $error("threshold B low readback wrong");
  property p_thr_a_lo;
    reg_read_i && reg_addr_i == 8'h14
      |=> reg_rdata_o == $past(talk_threshold_a_o[7:0]);
  endproperty
  a_thr_a_lo: assert property (p_thr_a_lo)
    else $error("threshold A low readback wrong");
  property p_wr_a_lo;
    reg_write_i && reg_addr_i == 8'h14
      |=> talk_threshold_a_o[7:0] == $past(reg_wdata_i);
  endproperty
  a_wr_a_lo: assert property (p_wr_a_lo)
    else $error("threshold A low write not applied");
  property p_wr_b_hi;
    reg_write_i && reg_addr_i == 8'h35
      |=> talk_threshold_b_o[15:8] == $past(reg_wdata_i);
  endproperty
  a_wr_b_hi: assert property (p_wr_b_hi)
    else $error("threshold B high write not applied");
  // Only a host write may move a threshold
  property p_thr_hold;
    !reg_write_i |=> $stable(talk_threshold_a_o) && $stable(talk_threshold_b_o);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("threshold changed without a write");
  property p_thr_reset;
    $rose(reset_n_i) |-> talk_threshold_b_o == 16'h4800;
  endproperty
  a_thr_reset: assert property (p_thr_reset)
    else $error("threshold B not at reset value");
  property p_dt_hold;
    !sample_valid_a_i |=> $stable(double_talk_a_o);
  endproperty
  a_dt_hold: assert property (p_dt_hold)
    else $error("double talk A moved without a sample");
endmodule

/* File: testbench/echo_peak_and_dtd_regs_tb.sv */
module echo_peak_and_dtd_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, reset_n_i, wr_i, rd_i, sva, svb, dta, dtb;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] sa, ea, ra, sb, eb, rb, tha, thb;
  int err_count = 0;
  int samples_checked = 0;
  echo_peak_and_dtd_regs u_echo_peak_and_dtd_regs (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr_i), .reg_read_i(rd_i),
    .reg_rdata_o(rdata), .sample_valid_a_i(sva), .send_sample_a_i(sa),
    .error_sample_a_i(ea), .receive_sample_a_i(ra),
    .sample_valid_b_i(svb), .send_sample_b_i(sb),
    .error_sample_b_i(eb), .receive_sample_b_i(rb),
    .double_talk_a_o(dta), .double_talk_b_o(dtb),
    .talk_threshold_a_o(tha), .talk_threshold_b_o(thb)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("rdata at %h", a), {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic smp(input logic [15:0] s_a, e_a, r_a, s_b, e_b, r_b);
    @(posedge clk_sys_i);
    {sa, ea, ra, sb, eb, rb} <= {s_a, e_a, r_a, s_b, e_b, r_b};
    {sva, svb} <= 2'b11;
    @(posedge clk_sys_i);
    {sva, svb} <= 2'b00;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("threshold A", 16'h4800, tha);
    chk("threshold B", 16'h4800, thb);
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h48);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h48);
    rd(8'h20, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_thr;
    wr(8'h14, 8'h12);
    chk("threshold A", 16'h4812, tha);
    wr(8'h15, 8'h7F);
    wr(8'h34, 8'hAB);
    wr(8'h35, 8'h80);
    chk("threshold B", 16'h80AB, thb);
    rd(8'h14, 8'h12);
    rd(8'h15, 8'h7F);
    rd(8'h34, 8'hAB);
    rd(8'h35, 8'h80);
    $display("t_thr done");
  endtask
  task automatic t_peak;
    smp(16'h1234, 16'hFF00, 16'h0000, 16'h8000, 16'h0055, 16'h0000);
    rd(8'h0E, 8'h34);
    rd(8'h0F, 8'h12);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h01);
    rd(8'h2E, 8'hFF);
    rd(8'h2F, 8'h7F);
    rd(8'h30, 8'h55);
    rd(8'h31, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h2F, 8'h00);
    wr(8'h20, 8'h55);
    chk("threshold A", 16'h7F12, tha);
    chk("threshold B", 16'h80AB, thb);
    rd(8'h0E, 8'h34);
    rd(8'h2F, 8'h7F);
    $display("t_peak done");
  endtask
  // Receive peak 0x4000 scales the threshold to half its value
  task automatic t_dt;
    wr(8'h15, 8'h48);
    wr(8'h14, 8'h00);
    smp(16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
    chk("double talk A", 16'h0000, {15'h0000, dta});
    smp(16'h2401, 16'h0000, 16'h4000, 16'h0001, 16'h0000, 16'h0000);
    chk("double talk A", 16'h0001, {15'h0000, dta});
    chk("double talk B", 16'h0001, {15'h0000, dtb});
    smp(16'h2400, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
    chk("double talk A", 16'h0000, {15'h0000, dta});
    wr(8'h15, 8'h20);
    smp(16'h1001, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
    chk("double talk A", 16'h0001, {15'h0000, dta});
    smp(16'h1000, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
    chk("double talk A", 16'h0000, {15'h0000, dta});
    $display("t_dt done");
  endtask
  // Peak drops by 0x1FF between the two byte reads; the high byte stays frozen
  task automatic t_freeze;
    smp(16'h7FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    rd(8'h0E, 8'hFF);
    smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    rd(8'h0F, 8'h7F);
    rd(8'h0F, 8'h7E);
    rd(8'h0E, 8'h00);
    $display("t_freeze done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cuts a hang short
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    {reset_n_i, wr_i, rd_i, sva, svb} = 5'h00;
    {addr, wdata} = 16'h0000;
    {sa, ea, ra, sb, eb, rb} = '0;
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    t_reset();
    t_thr();
    t_peak();
    t_dt();
    t_freeze();
    close_out();
  end
endmodule

bind echo_peak_and_dtd_regs echo_regs_checker u_echo_regs_checker (
  .clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .sample_valid_a_i, .double_talk_a_o,
  .talk_threshold_a_o, .talk_threshold_b_o
);
